//--- rtl/tsp_regs.vh
// Register map, field positions and reset values of the touch state processor
`ifndef TSP_REGS_VH
`define TSP_REGS_VH

`define TSP_OFF_CTRL 8'h00
`define TSP_OFF_THRESH 8'h04
`define TSP_OFF_NOISE 8'h08
`define TSP_OFF_COUNT 8'h0c
`define TSP_OFF_STATE 8'h10
`define TSP_OFF_STATUS 8'h14
`define TSP_OFF_CLEAR 8'h18
`define TSP_OFF_IRQEN 8'h1c
`define TSP_OFF_LAST 8'h20

`define TSP_CTRL_EN 0
`define TSP_CTRL_LOWPWR 1
`define TSP_CTRL_AUTORST 2
`define TSP_CTRL_GUARD 3
`define TSP_CTRL_MATRIX 4
`define TSP_CTRL_RES_LSB 8
`define TSP_CTRL_DIV_LSB 16

`define TSP_STATE_LPACT 16
`define TSP_STATE_GUARD 17
`define TSP_STATE_MVALID 24
`define TSP_STATE_MROW_LSB 25
`define TSP_STATE_MCOL_LSB 28

`define TSP_CTRL_RST 32'h00020c00
`define TSP_THRESH_RST 32'h000a0050
`define TSP_NOISE_RST 32'h00140028
`define TSP_COUNT_RST 32'h00000503

`define TSP_EV_CHANGE 0
`define TSP_EV_LOWRST 1
`define TSP_EV_ROUND 2
`define TSP_EV_GUARD 3
`define TSP_EV_W 4

`define TSP_RES_MIN 5'h01
`define TSP_RES_MAX 5'h10
`define TSP_FILT_SHIFT 3

`endif

//--- rtl/tsp_scan.v
// Sensor scan timer: counts modulator bits over one scan window
`default_nettype none

module tsp_scan #(
   parameter RW = 16
) (
   input wire clock,
   input wire reset,
   input wire start,
   input wire [4:0] res,
   input wire [7:0] div,
   input wire mod_bit,
   output wire busy,
   output wire done,
   output wire [RW-1:0] raw
);

   reg busy_q;
   reg done_q;
   reg [RW-1:0] raw_q;
   reg [7:0] div_q;
   reg [RW-1:0] tick_q;
   wire [RW:0] full;
   wire [RW:0] tick_n;

   assign full = ({{RW{1'b0}}, 1'b1} << res) - {{RW{1'b0}}, 1'b1};
   assign tick_n = {1'b0, tick_q} + {{RW{1'b0}}, 1'b1};
   assign busy = busy_q;
   assign done = done_q;
   assign raw = raw_q;

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         raw_q <= {RW{1'b0}};
         div_q <= 8'h00;
         tick_q <= {RW{1'b0}};
      end else begin
         done_q <= 1'b0;
         if (start && !busy_q) begin
            busy_q <= 1'b1;
            div_q <= div;
            tick_q <= {RW{1'b0}};
            raw_q <= {RW{1'b0}};
         end else if (busy_q) begin
            if (div_q == 8'h00) begin
               div_q <= div;
               raw_q <= raw_q + {{(RW-1){1'b0}}, mod_bit};
               tick_q <= tick_n[RW-1:0];
               if (tick_n == full) begin
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
               end
            end else begin
               div_q <= div_q - 8'h01;
            end
         end
      end
   end

endmodule
`default_nettype wire

//--- rtl/tsp_core.v
// Touch state processor: baseline, difference, debounce, scan sequencing, AHB-Lite
//
// Operation
// - difference is raw minus baseline, else zero
// - ON above threshold plus hysteresis
// - OFF below threshold minus hysteresis, else hold
// - touch reported after debounce consecutive samples
// - baseline tracks within negative noise below, within noise above unless auto reset
// - long negative excursion reloads baseline
// - scan lasts two-to-N minus one ticks
// - modulator tick samples bit and counts
// - matrix reports one intersection at most
// - ganged low-power scan, touch goes active
// - triggered guard suppresses other sensors
// - button state is only on or off
// - auto reset chooses baseline update condition
`include "tsp_regs.vh"
`default_nettype none

module tsp_core #(
   parameter NS = 8,
   parameter RW = 16,
   parameter MR = 3,
   parameter MC = 3
) (
   input wire clock,
   input wire reset,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   input wire mod_bit,
   output reg [NS-1:0] sense_sel,
   output reg sense_gang,
   output reg [NS-1:0] touch_state,
   output reg matrix_valid,
   output reg irq
);

   localparam CW = $clog2(NS + 1);
   localparam GUARD = NS - 1;
   localparam S_IDLE = 2'd0;
   localparam S_START = 2'd1;
   localparam S_WAIT = 2'd2;
   localparam S_PROC = 2'd3;

   function [3:0] pop;
      input [15:0] v;
      integer k;
      begin
         pop = 4'h0;
         for (k = 0; k < 16; k = k + 1)
            pop = pop + {3'b000, v[k]};
      end
   endfunction

   function [2:0] first;
      input [15:0] v;
      integer k;
      begin
         first = 3'd0;
         for (k = 7; k >= 0; k = k - 1)
            if (v[k])
               first = k[2:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register file
   reg [31:0] ctrl_q;
   reg [31:0] thresh_q;
   reg [31:0] noise_q;
   reg [31:0] count_q;
   reg [`TSP_EV_W-1:0] stat_q;
   reg [`TSP_EV_W-1:0] ien_q;
   reg [31:0] last_q;
   reg wr_pend_q;
   reg [7:0] wr_addr_q;
   reg [31:0] rd_d;
   reg [`TSP_EV_W-1:0] clr_d;
   reg [`TSP_EV_W-1:0] ev_d;
   wire [`TSP_EV_W-1:0] stat_d;
   wire ahb_go;

   ////////////////////////////////////////////////////////////////////////
   // Per-sensor state; slot NS holds the ganged sensor
   reg [RW-1:0] bl_q [0:NS];
   reg [7:0] deb_q [0:NS];
   reg [7:0] low_q [0:NS];
   reg [NS:0] st_q;
   reg [NS:0] init_q;
   reg [1:0] fsm_q;
   reg [CW-1:0] cur_q;
   reg [CW-1:0] idx_q;
   reg lp_act_q;
   reg any_on_q;
   reg [2:0] mrow_q;
   reg [2:0] mcol_q;

   wire scan_busy;
   wire scan_done;
   wire [RW-1:0] scan_raw;
   wire [4:0] res_raw = ctrl_q[`TSP_CTRL_RES_LSB +: 5];
   wire [4:0] res = (res_raw < `TSP_RES_MIN) ? `TSP_RES_MIN :
                    (res_raw > `TSP_RES_MAX) ? `TSP_RES_MAX : res_raw;
   wire en = ctrl_q[`TSP_CTRL_EN];
   wire lowpwr = ctrl_q[`TSP_CTRL_LOWPWR];
   wire autorst = ctrl_q[`TSP_CTRL_AUTORST];
   wire guard_en = ctrl_q[`TSP_CTRL_GUARD];
   wire mtx_en = ctrl_q[`TSP_CTRL_MATRIX];
   wire [15:0] fthr = thresh_q[15:0];
   wire [15:0] hyst = thresh_q[31:16];
   wire [15:0] nthr = noise_q[15:0];
   wire [15:0] negthr = noise_q[31:16];
   wire [7:0] debn = count_q[7:0];
   wire [7:0] lbr = count_q[15:8];
   wire guard_trip = guard_en && st_q[GUARD];

   tsp_scan #(.RW(RW)) u_scan (
      .clock(clock),
      .reset(reset),
      .start(fsm_q == S_START),
      .res(res),
      .div(ctrl_q[`TSP_CTRL_DIV_LSB +: 8]),
      .mod_bit(mod_bit),
      .busy(scan_busy),
      .done(scan_done),
      .raw(scan_raw)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sample processing for the slot under scan
   reg [RW-1:0] b;
   reg above;
   reg [RW-1:0] dpos;
   reg [RW-1:0] dneg;
   reg [RW-1:0] diff;
   reg [RW-1:0] step;
   reg [RW-1:0] bl_f;
   reg [16:0] hi;
   reg [15:0] lo;
   reg neg_ex;
   reg upd;
   reg [7:0] deb_n;
   reg [7:0] low_n;
   reg st_n;
   reg lowrst;

   always @* begin
      b = bl_q[cur_q];
      above = scan_raw > b;
      dpos = scan_raw - b;
      dneg = b - scan_raw;
      // negative or sub-noise clips to zero
      diff = (above && dpos >= nthr) ? dpos : {RW{1'b0}};
      // shifted step, never stalls at zero
      step = (above ? dpos : dneg) >> `TSP_FILT_SHIFT;
      if (step == {RW{1'b0}} && scan_raw != b)
         step = {{(RW-1){1'b0}}, 1'b1};
      bl_f = above ? b + step : b - step;
      hi = {1'b0, fthr} + {1'b0, hyst};
      lo = (fthr > hyst) ? fthr - hyst : 16'h0000;
      neg_ex = !above && dneg > negthr;
      upd = (above || dneg < negthr) && (autorst || diff < nthr);
      low_n = neg_ex ? low_q[cur_q] + 8'h01 : 8'h00;
      lowrst = neg_ex && low_n > lbr;
      st_n = st_q[cur_q];
      deb_n = 8'h00;
      if ({1'b0, diff} > hi) begin
         deb_n = deb_q[cur_q] + 8'h01;
         if (deb_n >= debn) begin
            st_n = 1'b1;
            deb_n = deb_q[cur_q];
         end
      end else if (diff < lo) begin
         st_n = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Matrix decode
   wire [15:0] rows = {{(16-MR){1'b0}}, st_q[MR-1:0]};
   wire [15:0] cols = {{(16-MC){1'b0}}, st_q[MR+MC-1:MR]};
   // exactly one row and one column
   wire mvalid_d = mtx_en && pop(rows) == 4'h1 && pop(cols) == 4'h1;

   ////////////////////////////////////////////////////////////////////////
   // Scan sequencer
   integer i;

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         fsm_q <= S_IDLE;
         cur_q <= {CW{1'b0}};
         idx_q <= {CW{1'b0}};
         lp_act_q <= 1'b0;
         any_on_q <= 1'b0;
         st_q <= {(NS+1){1'b0}};
         init_q <= {(NS+1){1'b0}};
         sense_sel <= {NS{1'b0}};
         sense_gang <= 1'b0;
         last_q <= 32'h0;
         for (i = 0; i <= NS; i = i + 1) begin
            bl_q[i] <= {RW{1'b0}};
            deb_q[i] <= 8'h00;
            low_q[i] <= 8'h00;
         end
      end else begin
         case (fsm_q)
            S_IDLE: begin
               sense_sel <= {NS{1'b0}};
               sense_gang <= 1'b0;
               if (en && !scan_busy) begin
                  fsm_q <= S_START;
                  if (lowpwr && !lp_act_q) begin
                     cur_q <= NS[CW-1:0];
                     sense_sel <= {NS{1'b1}};
                     sense_gang <= 1'b1;
                  end else if (guard_trip) begin
                     cur_q <= GUARD[CW-1:0];
                     sense_sel <= {NS{1'b0}} | ({{(NS-1){1'b0}}, 1'b1} << GUARD);
                  end else begin
                     cur_q <= idx_q;
                     sense_sel <= {{(NS-1){1'b0}}, 1'b1} << idx_q;
                  end
               end
            end
            S_START: begin
               fsm_q <= S_WAIT;
            end
            S_WAIT: begin
               if (scan_done)
                  fsm_q <= S_PROC;
            end
            S_PROC: begin
               fsm_q <= S_IDLE;
               sense_sel <= {NS{1'b0}};
               sense_gang <= 1'b0;
               last_q <= {diff, scan_raw};
               init_q[cur_q] <= 1'b1;
               if (!init_q[cur_q]) begin
                  // First sample seeds the baseline
                  bl_q[cur_q] <= scan_raw;
               end else begin
                  st_q[cur_q] <= st_n;
                  deb_q[cur_q] <= deb_n;
                  low_q[cur_q] <= lowrst ? 8'h00 : low_n;
                  if (lowrst)
                     bl_q[cur_q] <= scan_raw;
                  else if (upd)
                     bl_q[cur_q] <= bl_f;
               end
               if (cur_q == NS[CW-1:0]) begin
                  // touch on gang switches to active
                  if (st_n && init_q[cur_q]) begin
                     lp_act_q <= 1'b1;
                     idx_q <= {CW{1'b0}};
                     any_on_q <= 1'b0;
                  end
               end else if (!guard_trip) begin
                  any_on_q <= any_on_q | st_n;
                  if (idx_q == GUARD[CW-1:0]) begin
                     idx_q <= {CW{1'b0}};
                     any_on_q <= 1'b0;
                     // Quiet round returns to ganged scanning
                     if (!(any_on_q | st_n))
                        lp_act_q <= 1'b0;
                  end else begin
                     idx_q <= idx_q + {{(CW-1){1'b0}}, 1'b1};
                  end
               end
            end
            default: begin
               fsm_q <= S_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Events
   always @* begin
      ev_d = {`TSP_EV_W{1'b0}};
      if (fsm_q == S_PROC && init_q[cur_q]) begin
         ev_d[`TSP_EV_CHANGE] = st_n != st_q[cur_q];
         ev_d[`TSP_EV_LOWRST] = lowrst;
         ev_d[`TSP_EV_ROUND] = cur_q == GUARD[CW-1:0] && !guard_trip;
         ev_d[`TSP_EV_GUARD] = cur_q == GUARD[CW-1:0] && guard_en && st_n &&
                               !st_q[GUARD];
      end
   end

   // Set beats a simultaneous clear
   assign stat_d = (stat_q & ~clr_d) | ev_d;

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   assign ahb_go = hsel && htrans[1] && hready;

   always @* begin
      rd_d = 32'h0;
      case (haddr[7:0])
         `TSP_OFF_CTRL: rd_d = ctrl_q;
         `TSP_OFF_THRESH: rd_d = thresh_q;
         `TSP_OFF_NOISE: rd_d = noise_q;
         `TSP_OFF_COUNT: rd_d = count_q;
         `TSP_OFF_STATE: begin
            rd_d[NS-1:0] = st_q[NS-1:0];
            rd_d[`TSP_STATE_LPACT] = lp_act_q;
            rd_d[`TSP_STATE_GUARD] = guard_trip;
            rd_d[`TSP_STATE_MVALID] = matrix_valid;
            rd_d[`TSP_STATE_MROW_LSB +: 3] = mrow_q;
            rd_d[`TSP_STATE_MCOL_LSB +: 3] = mcol_q;
         end
         `TSP_OFF_STATUS: rd_d[`TSP_EV_W-1:0] = stat_q;
         `TSP_OFF_IRQEN: rd_d[`TSP_EV_W-1:0] = ien_q;
         `TSP_OFF_LAST: rd_d = last_q;
         default: rd_d = 32'h0;
      endcase
   end

   always @* begin
      clr_d = {`TSP_EV_W{1'b0}};
      if (wr_pend_q && wr_addr_q == `TSP_OFF_CLEAR)
         clr_d = hwdata[`TSP_EV_W-1:0];
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         ctrl_q <= `TSP_CTRL_RST;
         thresh_q <= `TSP_THRESH_RST;
         noise_q <= `TSP_NOISE_RST;
         count_q <= `TSP_COUNT_RST;
         stat_q <= {`TSP_EV_W{1'b0}};
         ien_q <= {`TSP_EV_W{1'b0}};
         irq <= 1'b0;
         touch_state <= {NS{1'b0}};
         matrix_valid <= 1'b0;
         mrow_q <= 3'd0;
         mcol_q <= 3'd0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= ahb_go && hwrite;
         wr_addr_q <= haddr[7:0];
         if (ahb_go && !hwrite)
            hrdata <= rd_d;
         if (wr_pend_q) begin
            case (wr_addr_q)
               `TSP_OFF_CTRL: ctrl_q <= hwdata;
               `TSP_OFF_THRESH: thresh_q <= hwdata;
               `TSP_OFF_NOISE: noise_q <= hwdata;
               `TSP_OFF_COUNT: count_q <= hwdata;
               `TSP_OFF_IRQEN: ien_q <= hwdata[`TSP_EV_W-1:0];
               default: ;
            endcase
         end
         stat_q <= stat_d;
         irq <= |(stat_d & ien_q);
         touch_state <= st_q[NS-1:0];
         matrix_valid <= mvalid_d;
         mrow_q <= mvalid_d ? first(rows) : 3'd0;
         mcol_q <= mvalid_d ? first(cols) : 3'd0;
      end
   end

endmodule
`default_nettype wire

//--- test/tsp_core_sva.sv
// Port-level assertions for the touch state processor
`default_nettype none
module tsp_core_sva #(
   parameter NS = 8,
   parameter MR = 3,
   parameter MC = 3
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [NS-1:0] sense_sel,
   input wire logic sense_gang,
   input wire logic [NS-1:0] touch_state,
   input wire logic matrix_valid,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   wire logic rd_ap = hsel && htrans[1] && hready && !hwrite;
   wire logic wr_ap = hsel && htrans[1] && hready && hwrite;
   wire logic sel_any = |sense_sel;
   property p_bus_ok;
      hreadyout && !hresp;
   endproperty
   a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or error");
   property p_rd_hold;
      !$stable(hrdata) |-> $past(rd_ap);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved unasked");
   // Only a clear or enable write can drop the request
   property p_irq_fall;
      $fell(irq) |-> $past(wr_ap, 2) || $past(wr_ap, 3) || $past(wr_ap, 4);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
   property p_gang;
      sense_gang |-> &sense_sel;
   endproperty
   a_gang: assert property (p_gang) else $error("ganged scan not all sensors");
   property p_onehot;
      !sense_gang |-> $onehot0(sense_sel);
   endproperty
   a_onehot: assert property (p_onehot) else $error("several sensors selected");
   property p_sel_hold;
      !$stable(sense_sel) |-> sense_sel == '0 || $past(sense_sel) == '0;
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("sensor swapped mid scan");
   property p_scan_min;
      $rose(sel_any) |=> $stable(sense_sel) [*2];
   endproperty
   a_scan_min: assert property (p_scan_min) else $error("scan too short");
   property p_state_one;
      $onehot0(touch_state ^ $past(touch_state));
   endproperty
   a_state_one: assert property (p_state_one) else $error("two states moved");
   property p_state_slot;
      $changed(touch_state) |-> $past(sel_any) || $past(sel_any, 2) || $past(sel_any, 3);
   endproperty
   a_state_slot: assert property (p_state_slot) else $error("state moved off scan");
   property p_matrix;
      matrix_valid && touch_state == $past(touch_state, 2) |->
         $onehot(touch_state[MR-1:0]) && $onehot(touch_state[MR+MC-1:MR]);
   endproperty
   a_matrix: assert property (p_matrix) else $error("matrix valid not single");
   c_on: cover property ($rose(touch_state[2]));
   c_matrix: cover property (matrix_valid);
   c_gang: cover property ($fell(sense_gang));
   c_irq: cover property ($fell(irq));
endmodule
bind tsp_core tsp_core_sva #(.NS(NS), .MR(MR), .MC(MC)) u_sva (.clock(clock), .reset(reset),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .sense_sel(sense_sel), .sense_gang(sense_gang),
   .touch_state(touch_state), .matrix_valid(matrix_valid), .irq(irq));
`default_nettype wire

//--- test/tsp_front.sv
// Behavioural sensing front end: modulator bit per selected electrode
`default_nettype none
module tsp_front #(
   parameter NS = 8
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [NS-1:0] sense_sel,
   input wire logic [NS-1:0] touch_mask,
   output logic mod_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_q;
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end
   // Finger saturates modulator; idle gives quarter duty, never a frozen level
   assign mod_bit = (|(sense_sel & touch_mask)) ? 1'b1 : (phase_q == 2'h0);
endmodule
`default_nettype wire

//--- test/touch_sensor_state_processor_tb.sv
// Self-checking bench for the touch state processor
`include "tsp_regs.vh"
`default_nettype none
module touch_sensor_state_processor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] touch_mask = 8'h00;
   logic hreadyout, hresp, matrix_valid, irq, mod_bit, sense_gang;
   logic [31:0] hrdata, q;
   logic [7:0] sense_sel, touch_state;
   wire logic hready = hreadyout;
   int num_errors = 0;
   int num_checks = 0;
   int n;
   initial begin
      forever #5 clock = ~clock;
   end
   tsp_core #(.NS(8), .RW(16), .MR(3), .MC(3)) dut_u (.clock(clock), .reset(reset),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .mod_bit(mod_bit), .sense_sel(sense_sel), .sense_gang(sense_gang),
      .touch_state(touch_state), .matrix_valid(matrix_valid), .irq(irq));
   tsp_front #(.NS(8)) front_u (.clock(clock), .reset(reset), .sense_sel(sense_sel),
      .touch_mask(touch_mask), .mod_bit(mod_bit));
   ////////////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      if (num_errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic hang(input string m);
      num_errors++;
      $display("[FAIL] %0t %s timed out", $time, m);
      conclude;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic rdy;
      int k;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (hready !== 1'b1 && k < 20);
      if (hready !== 1'b1) hang("bus");
   endtask
   // Address phase held until ready, then data phase; read data taken at its end
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy;
      r = hrdata;
   endtask
   task automatic do_reset;
      touch_mask <= 8'h00;
      reset <= 1'b1;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
   endtask
   // Waits for k completed scans of sensor s
   task automatic samp(input int s, input int k);
      logic p;
      repeat (k) begin
         n = 0;
         p = 1'b0;
         while (!(p === 1'b1 && sense_sel[s] !== 1'b1)) begin
            p = sense_sel[s];
            @(posedge clock);
            n++;
            if (n > 9000) hang("scan");
         end
      end
      repeat (3) @(posedge clock);
   endtask
   task automatic wait_on(input int s, input logic v);
      n = 0;
      while (touch_state[s] !== v && n < 30000) begin
         @(posedge clock);
         n++;
      end
      if (touch_state[s] !== v) hang("state");
      repeat (3) @(posedge clock);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [31:0] e [4];
      e = '{`TSP_CTRL_RST, `TSP_THRESH_RST, `TSP_NOISE_RST, `TSP_COUNT_RST};
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 8'(4 * i), 32'h0, q);
         chk(q, e[i], "reset value");
      end
      bus(1'b1, `TSP_OFF_THRESH, 32'h000c0064, q);
      bus(1'b1, `TSP_OFF_STATUS, 32'h0000000f, q);
      bus(1'b1, 8'h24, 32'hffffffff, q);
      bus(1'b0, `TSP_OFF_THRESH, 32'h0, q);
      chk(q, 32'h000c0064, "thresh rw");
      bus(1'b0, `TSP_OFF_STATUS, 32'h0, q);
      chk(q, 32'h0, "status ro");
      bus(1'b0, 8'h24, 32'h0, q);
      chk(q, 32'h0, "unmapped");
   endtask
   // Scan lasts 2^N-1 ticks, each D+1 clocks long
   task automatic t_scan;
      int len [4];
      for (int i = 0; i < 4; i++) begin
         do_reset;
         touch_mask <= 8'hff;
         bus(1'b1, `TSP_OFF_CTRL, 32'(32'h401 + (i % 2) * 32'h100 + (i / 2) * 32'h10000), q);
         n = 0;
         while (sense_sel[0] !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
         end
         if (sense_sel[0] !== 1'b1) hang("scan start");
         len[i] = 0;
         while (sense_sel[0] === 1'b1 && len[i] < 200) begin
            @(posedge clock);
            len[i]++;
         end
         if (len[i] >= 200) hang("scan end");
         repeat (3) @(posedge clock);
         bus(1'b0, `TSP_OFF_LAST, 32'h0, q);
         chk(q & 32'hffff, (i % 2) ? 32'd31 : 32'd15, "full raw");
      end
      chk(32'(len[1] - len[0]), 32'd16, "scan length");
      chk(32'(len[3] - len[2]), 32'd32, "divided length");
   endtask
   task automatic t_touch;
      do_reset;
      bus(1'b1, `TSP_OFF_IRQEN, 32'h1, q);
      bus(1'b1, `TSP_OFF_CTRL, 32'h801, q);
      samp(2, 1);
      touch_mask <= 8'h04;
      samp(2, 2);
      chk(touch_state, 8'h00, "early touch");
      chk(irq, 1'b0, "irq early");
      samp(2, 1);
      chk(touch_state, 8'h04, "touch on");
      bus(1'b0, `TSP_OFF_STATE, 32'h0, q);
      chk(q & 32'hff, 32'h04, "state reg");
      chk(irq, 1'b1, "irq set");
      bus(1'b1, `TSP_OFF_IRQEN, 32'h0, q);
      bus(1'b0, `TSP_OFF_STATUS, 32'h0, q);
      chk(q & 32'h1, 32'h1, "sticky");
      chk(irq, 1'b0, "irq masked");
      bus(1'b1, `TSP_OFF_IRQEN, 32'h1, q);
      bus(1'b1, `TSP_OFF_CLEAR, 32'h1, q);
      chk(irq, 1'b1, "irq unmasked");
      repeat (2) @(posedge clock);
      chk(irq, 1'b0, "irq cleared");
      samp(2, 1);
      chk(touch_state, 8'h04, "held on");
      bus(1'b1, `TSP_OFF_CTRL, 32'h805, q);
      samp(2, 1);
      chk(touch_state, 8'h04, "slow baseline");
      wait_on(2, 1'b0);
      chk(touch_state, 8'h00, "auto reset");
   endtask
   // Finger present from power-up, then lifted
   task automatic t_lowrst;
      do_reset;
      bus(1'b1, `TSP_OFF_CTRL, 32'h801, q);
      touch_mask <= 8'h20;
      samp(5, 1);
      touch_mask <= 8'h00;
      samp(5, 1);
      bus(1'b0, `TSP_OFF_LAST, 32'h0, q);
      chk(q >> 16, 32'h0, "negative diff");
      samp(5, 4);
      bus(1'b0, `TSP_OFF_STATUS, 32'h0, q);
      chk(q & 32'h2, 32'h0, "early reload");
      samp(5, 1);
      bus(1'b0, `TSP_OFF_STATUS, 32'h0, q);
      chk(q & 32'h2, 32'h2, "reload");
      touch_mask <= 8'h20;
      samp(5, 3);
      chk(touch_state, 8'h20, "touch after reload");
   endtask
   task automatic t_guard;
      logic bad;
      do_reset;
      bus(1'b1, `TSP_OFF_CTRL, 32'h809, q);
      samp(7, 1);
      touch_mask <= 8'h80;
      samp(7, 4);
      chk(touch_state, 8'h80, "guard on");
      bus(1'b0, `TSP_OFF_STATUS, 32'h0, q);
      chk(q & 32'hc, 32'hc, "guard and round events");
      bad = 1'b0;
      repeat (1500) begin
         @(posedge clock);
         if ((sense_sel & 8'h7f) !== 8'h00) bad = 1'b1;
      end
      chk(bad, 1'b0, "guard lockout");
      touch_mask <= 8'h00;
      samp(7, 1);
      samp(1, 1);
      chk(touch_state, 8'h00, "guard off");
   endtask
   task automatic t_lowpwr;
      do_reset;
      bus(1'b1, `TSP_OFF_CTRL, 32'h801, q);
      samp(7, 1);
      bus(1'b1, `TSP_OFF_CTRL, 32'h803, q);
      n = 0;
      while (sense_gang !== 1'b1 && n < 3000) begin
         @(posedge clock);
         n++;
      end
      chk(sense_gang, 1'b1, "ganged scan");
      while (sense_gang === 1'b1 && n < 4000) begin
         @(posedge clock);
         n++;
      end
      if (sense_gang === 1'b1) hang("gang");
      touch_mask <= 8'h08;
      wait_on(3, 1'b1);
      chk(touch_state, 8'h08, "active found");
      chk(sense_gang, 1'b0, "left gang");
      bus(1'b0, `TSP_OFF_STATE, 32'h0, q);
      chk(q & 32'h10008, 32'h10008, "active state reg");
   endtask
   task automatic t_matrix;
      do_reset;
      bus(1'b1, `TSP_OFF_CTRL, 32'h811, q);
      samp(7, 1);
      touch_mask <= 8'h09;
      wait_on(3, 1'b1);
      chk(matrix_valid, 1'b1, "one crossing");
      bus(1'b0, `TSP_OFF_STATE, 32'h0, q);
      chk(q, 32'h01000009, "crossing reg");
      touch_mask <= 8'h0b;
      samp(1, 3);
      chk(matrix_valid, 1'b0, "two crossings");
      touch_mask <= 8'h03;
      samp(3, 1);
      chk(touch_state, 8'h03, "column off");
   endtask
   ////////////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset;
      t_regs;
      t_scan;
      t_touch;
      t_lowrst;
      t_guard;
      t_lowpwr;
      t_matrix;
      conclude;
   end
endmodule
`default_nettype wire
